// file: hw/kms_defs.svh
// Purpose: constants for the keyboard/mouse shift engine
// Assumes: byte-wide register port, 3-bit word address
// Notes: register offsets are word indices on the plain port
`ifndef KMS_DEFS_SVH
`define KMS_DEFS_SVH

`define KMS_ADDR_W 3
`define KMS_OFS_DATA 3'h0
`define KMS_OFS_STATUS 3'h1
`define KMS_OFS_CONTROL 3'h2
`define KMS_OFS_LINE_OUT 3'h3
`define KMS_OFS_LINE_IN 3'h4
`define KMS_OFS_IRQ_EN 3'h5

`define KMS_RST_CONTROL 8'h00
`define KMS_RST_LINE_OUT 6'h07
`define KMS_RST_IRQ_EN 3'h0
`define KMS_RST_DATA 8'h00

// debounce select above this value saturates at the longest window
`define KMS_IDB_MAX 3'h5
`define KMS_DB_CNT_W 6

// falling-edge counts after the start bit
`define KMS_LAST_DATA_FALL 4'h8
`define KMS_PARITY_FALL 4'h9
`define KMS_STOP_FALL 4'hA

`endif

// file: hw/kms_pkg.sv
// Purpose: types shared by the shift engine
// Assumes: nothing beyond SystemVerilog packages
// Notes: struct layouts match the register bit order
package kms_pkg;

  typedef enum logic [1:0] {
    KMS_INACTIVE = 2'h0,
    KMS_IDLE = 2'h1,
    KMS_ACTIVE = 2'h3,
    KMS_END = 2'h2
  } kms_state_t;

  typedef struct packed {
    logic reserved;
    logic stop_bit_fault_flag;
    logic [2:0] active_channel;
    logic parity_fault_flag;
    logic transfer_done_flag;
    logic start_seen_flag;
  } kms_status_t;

  typedef struct packed {
    logic weak_pullup_enable;
    logic [2:0] input_debounce_field;
    logic [1:0] high_drive;
    logic transmit_direction;
    logic engine_enable;
  } kms_control_t;

  typedef struct packed {
    logic [2:0] channel_enable;
    logic [2:0] data_drive_bit;
  } kms_line_out_t;

endpackage

// file: hw/kms_shift_engine.sv
// Purpose: shift engine for three two-wire keyboard/mouse ports
// Assumes: peripheral supplies the port clock; pins are open drain
// Notes: registers reached over a plain byte port, read data one cycle late
`include "kms_defs.svh"

module kms_shift_engine #(
  parameter int CHANNELS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`KMS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] port_clock_line_i,
  output logic [2:0] port_clock_line_o,
  output logic [2:0] port_clock_line_oe,
  input wire logic [2:0] port_data_line_i,
  output logic [2:0] port_data_line_o,
  output logic [2:0] port_data_line_oe,
  output logic weak_pullup_enable,
  output logic shift_interrupt_line,
  output logic [1:0] bitbang_irq_extra
);

  initial
  begin
    if (CHANNELS != 3)
      $error("engine serves exactly three channels");
  end

  kms_pkg::kms_state_t state;
  kms_pkg::kms_status_t status;
  kms_pkg::kms_control_t control;
  kms_pkg::kms_line_out_t line_out;
  logic [2:0] irq_en;
  logic [7:0] shift_data_byte;
  logic [7:0] shift_reg;
  logic [3:0] fall_cnt;
  logic tx_bit;
  logic ones_odd;
  logic wait_line_control;
  logic [2:0] clk_meta;
  logic [2:0] clk_s;
  logic [2:0] dat_meta;
  logic [2:0] dat_s;
  logic [2:0] clk_db;
  logic [2:0] clk_db_prev;
  logic [2:0] fall;
  logic [2:0] start_hit;
  logic [2:0] start_pick;
  logic engine_reset;
  logic act_fall;
  logic act_data;
  logic [2:0] next_clk_oe;
  logic [2:0] next_dat_oe;
  logic [5:0] db_limit;

  // synchronisers: first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_meta <= 3'h7;
      clk_s <= 3'h7;
      dat_meta <= 3'h7;
      dat_s <= 3'h7;
    end
    else
    begin
      clk_meta <= port_clock_line_i;
      clk_s <= clk_meta;
      dat_meta <= port_data_line_i;
      dat_s <= dat_meta;
    end
  end

  // stable-window limit; unused codes saturate rather than wrap
  always_comb
  begin
    if (control.input_debounce_field > `KMS_IDB_MAX)
      db_limit = 6'h20;
    else
      db_limit = 6'(6'h01 << control.input_debounce_field);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_deb
      logic [`KMS_DB_CNT_W-1:0] cnt;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          cnt <= '0;
          clk_db[gi] <= 1'b1;
          clk_db_prev[gi] <= 1'b1;
        end
        else
        begin
          clk_db_prev[gi] <= clk_db[gi];
          if (clk_s[gi] == clk_db[gi])
            cnt <= '0;
          else if (cnt + 6'h01 >= db_limit)
          begin
            clk_db[gi] <= clk_s[gi];
            cnt <= '0;
          end
          else
            cnt <= cnt + 6'h01;
        end
      end
      assign fall[gi] = clk_db_prev[gi] & ~clk_db[gi];
    end
  endgenerate

  // engine held in reset when disabled or no channel enabled
  assign engine_reset = ~control.engine_enable | (line_out.channel_enable == 3'h0);
  // start bit: clock fall with data low on an enabled channel
  assign start_hit = fall & ~dat_s & line_out.channel_enable;
  // lower channel number wins a tie
  assign start_pick = start_hit[0] ? 3'h1 : (start_hit[1] ? 3'h2 : (start_hit[2] ? 3'h4 : 3'h0));
  assign act_fall = |(fall & status.active_channel);
  assign act_data = |(dat_s & status.active_channel);

  // state machine, shifter, status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= kms_pkg::KMS_INACTIVE;
      status <= '0;
      shift_reg <= '0;
      fall_cnt <= '0;
      tx_bit <= 1'b1;
      ones_odd <= 1'b0;
      wait_line_control <= 1'b0;
    end
    else if (engine_reset)
    begin
      state <= kms_pkg::KMS_INACTIVE;
      status <= '0;
      fall_cnt <= '0;
      tx_bit <= 1'b1;
      ones_odd <= 1'b0;
      wait_line_control <= 1'b0;
    end
    else
    begin
      case (state)
        kms_pkg::KMS_INACTIVE:
        begin
          state <= kms_pkg::KMS_IDLE;
        end
        kms_pkg::KMS_IDLE:
        begin
          if (start_pick != 3'h0)
          begin
            state <= kms_pkg::KMS_ACTIVE;
            status.start_seen_flag <= 1'b1;
            status.active_channel <= start_pick;
            fall_cnt <= 4'h0;
            ones_odd <= 1'b0;
            if (control.transmit_direction)
            begin
              shift_reg <= shift_data_byte;
              tx_bit <= shift_data_byte[0];
            end
          end
        end
        kms_pkg::KMS_ACTIVE:
        begin
          if (control.transmit_direction)
          begin
            if (wait_line_control)
            begin
              if (!act_data)
              begin
                state <= kms_pkg::KMS_END;
                status.transfer_done_flag <= 1'b1;
              end
            end
            else if (act_fall)
            begin
              fall_cnt <= fall_cnt + 4'h1;
              if (fall_cnt < 4'h7)
                tx_bit <= shift_reg[fall_cnt[2:0] + 3'h1];
              else if (fall_cnt == 4'h7)
                tx_bit <= ~(^shift_reg);
              else if (fall_cnt == 4'h8)
                tx_bit <= 1'b1;
              else
                wait_line_control <= 1'b1;
            end
          end
          else if (act_fall)
          begin
            fall_cnt <= fall_cnt + 4'h1;
            if (fall_cnt < `KMS_LAST_DATA_FALL)
            begin
              shift_reg <= {act_data, shift_reg[7:1]};
              ones_odd <= ones_odd ^ act_data;
            end
            else if (fall_cnt == `KMS_PARITY_FALL - 4'h1)
            begin
              if (!(ones_odd ^ act_data))
                status.parity_fault_flag <= 1'b1;
            end
            else
            begin
              state <= kms_pkg::KMS_END;
              status.transfer_done_flag <= 1'b1;
              if (!act_data)
                status.stop_bit_fault_flag <= 1'b1;
            end
          end
        end
        kms_pkg::KMS_END:
        begin
          state <= kms_pkg::KMS_END;
        end
        default:
        begin
          state <= kms_pkg::KMS_INACTIVE;
        end
      endcase
    end
  end

  // register port: writes, and received byte capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control <= `KMS_RST_CONTROL;
      line_out <= `KMS_RST_LINE_OUT;
      irq_en <= `KMS_RST_IRQ_EN;
      shift_data_byte <= `KMS_RST_DATA;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `KMS_OFS_DATA: shift_data_byte <= reg_wdata;
          `KMS_OFS_CONTROL: control <= reg_wdata;
          `KMS_OFS_LINE_OUT: line_out <= reg_wdata[5:0];
          `KMS_OFS_IRQ_EN: irq_en <= reg_wdata[2:0];
          default: ;
        endcase
      end
      // hardware set wins over a same-cycle software write
      if (!engine_reset && state == kms_pkg::KMS_IDLE && start_pick != 3'h0
          && control.transmit_direction)
        line_out.data_drive_bit <= 3'h7;
      if (!engine_reset && state == kms_pkg::KMS_ACTIVE && !control.transmit_direction
          && act_fall && fall_cnt == `KMS_LAST_DATA_FALL - 4'h1)
        shift_data_byte <= {act_data, shift_reg[7:1]};
    end
  end

  // read data for one cycle after the strobe only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `KMS_OFS_DATA: reg_rdata <= shift_data_byte;
        `KMS_OFS_STATUS: reg_rdata <= status;
        `KMS_OFS_CONTROL: reg_rdata <= control;
        `KMS_OFS_LINE_OUT: reg_rdata <= {2'h0, line_out};
        `KMS_OFS_LINE_IN: reg_rdata <= {2'h0, clk_s, dat_s};
        `KMS_OFS_IRQ_EN: reg_rdata <= {5'h00, irq_en};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // pin drive: an enable of one pulls the line low
  always_comb
  begin
    next_clk_oe = 3'h7;
    next_dat_oe = ~line_out.data_drive_bit;
    if (!control.engine_enable || engine_reset)
    begin
      next_clk_oe = ~line_out.channel_enable;
      next_dat_oe = ~line_out.data_drive_bit;
    end
    else
    begin
      case (state)
        kms_pkg::KMS_INACTIVE:
        begin
          next_clk_oe = 3'h7;
        end
        kms_pkg::KMS_IDLE:
        begin
          next_clk_oe = ~line_out.channel_enable;
        end
        kms_pkg::KMS_ACTIVE:
        begin
          next_clk_oe = ~status.active_channel;
          if (control.transmit_direction)
            next_dat_oe = tx_bit ? 3'h0 : status.active_channel;
        end
        kms_pkg::KMS_END:
        begin
          next_clk_oe = 3'h7;
          next_dat_oe = 3'h0;
        end
        default:
        begin
          next_clk_oe = 3'h7;
        end
      endcase
    end
  end

  // outputs all from flops; open-drain levels are always low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      port_clock_line_oe <= 3'h0;
      port_data_line_oe <= 3'h0;
      port_clock_line_o <= 3'h0;
      port_data_line_o <= 3'h0;
      weak_pullup_enable <= 1'b0;
      shift_interrupt_line <= 1'b0;
      bitbang_irq_extra <= 2'h0;
    end
    else
    begin
      port_clock_line_oe <= next_clk_oe;
      port_data_line_oe <= next_dat_oe;
      port_clock_line_o <= 3'h0;
      port_data_line_o <= 3'h0;
      weak_pullup_enable <= control.weak_pullup_enable;
      if (control.engine_enable)
      begin
        shift_interrupt_line <= (status.start_seen_flag & irq_en[0])
                              | (status.transfer_done_flag & irq_en[1]);
        bitbang_irq_extra <= 2'h0;
      end
      else
      begin
        shift_interrupt_line <= irq_en[2] & clk_s[0];
        bitbang_irq_extra <= irq_en[2] ? clk_s[2:1] : 2'h0;
      end
    end
  end

endmodule

// file: test/kms_shift_engine_properties.sv
// Purpose: port-level checks for the shift engine
// Assumes: only top ports visible; written registers mirrored locally
// Notes: mirror ignores hardware-set drive bits, so line checks hold only when disabled
`include "kms_defs.svh"
module kms_shift_engine_properties #(
  parameter int CHANNELS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`KMS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] port_clock_line_i,
  input wire logic [2:0] port_clock_line_o,
  input wire logic [2:0] port_clock_line_oe,
  input wire logic [2:0] port_data_line_o,
  input wire logic [2:0] port_data_line_oe,
  input wire logic shift_interrupt_line,
  input wire logic [1:0] bitbang_irq_extra
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en;
  logic bb;
  logic st_v;
  logic [5:0] lo;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      en <= 1'b0;
      bb <= 1'b0;
      lo <= 6'h07;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `KMS_OFS_CONTROL)
        en <= reg_wdata[0];
      if (reg_addr == `KMS_OFS_IRQ_EN)
        bb <= reg_wdata[2];
      if (reg_addr == `KMS_OFS_LINE_OUT)
        lo <= reg_wdata[5:0];
    end
  // marks the cycle in which read data carries the status byte
  always_ff @(posedge clk or posedge rst)
    if (rst)
      st_v <= 1'b0;
    else
      st_v <= reg_rd && reg_addr == `KMS_OFS_STATUS;
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  pin_out_zero_a: assert property (port_clock_line_o == 3'h0 && port_data_line_o == 3'h0)
    else $error("open drain output level not zero");
  end_clocks_a: assert property (st_v && reg_rdata[1] |-> port_clock_line_oe == 3'h7)
    else $error("clocks not held low after transfer end");
  ach_code_a: assert property (st_v |-> $onehot0(reg_rdata[5:3]))
    else $error("active channel code not one-hot");
  start_ach_a: assert property (st_v |-> reg_rdata[0] == (reg_rdata[5:3] != 3'h0))
    else $error("start flag and active channel disagree");
  done_start_a: assert property (st_v && reg_rdata[1] |-> reg_rdata[0] && !reg_rdata[7])
    else $error("done flag without start flag");
  abort_clocks_a: assert property (reg_wr && reg_addr == `KMS_OFS_LINE_OUT &&
      reg_wdata[5:3] == 3'h0 |-> ##[1:2] port_clock_line_oe == 3'h7)
    else $error("clocks not low after all channels off");
  bitbang_irq_a: assert property ((!en && bb && $stable(port_clock_line_i)) [*5] |->
      shift_interrupt_line == port_clock_line_i[0] && bitbang_irq_extra == port_clock_line_i[2:1])
    else $error("per-channel interrupts do not follow clock lines");
  manual_lines_a: assert property (!en && $past(en) == 1'b0 && $past(lo) == lo &&
      !$past(rst) |-> port_clock_line_oe == ~lo[5:3] && port_data_line_oe == ~lo[2:0])
    else $error("disabled engine lines do not follow control bits");
  cover property (st_v && reg_rdata[1]);
  cover property (st_v && reg_rdata[2]);
  cover property (!en && bb && bitbang_irq_extra == 2'h2);
endmodule
bind kms_shift_engine kms_shift_engine_properties #(.CHANNELS(CHANNELS)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_clock_line_i(port_clock_line_i),
  .port_clock_line_o(port_clock_line_o), .port_clock_line_oe(port_clock_line_oe),
  .port_data_line_o(port_data_line_o), .port_data_line_oe(port_data_line_oe),
  .shift_interrupt_line(shift_interrupt_line), .bitbang_irq_extra(bitbang_irq_extra)
);

// file: test/kms_peer_model.sv
// Purpose: keyboard-like peripheral on one channel, owns the port clock
// Assumes: lines resolved by the bench with pull-ups; 160 ns clock period
// Notes: clock stands released between frames
module kms_peer_model (
  output logic clk_low,
  output logic dat_low,
  input wire logic clk_line,
  input wire logic dat_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    clk_low = 1'b0;
    dat_low = 1'b0;
  end
  // start, data lsb first, parity, stop; data set well before each fall
  task automatic send_frame(input logic [7:0] b, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      dat_low = ~f[i];
      #40;
      clk_low = 1'b1;
      #80;
      clk_low = 1'b0;
      #40;
    end
    dat_low = 1'b0;
  endtask
  task automatic recv_frame(output logic [9:0] f, output logic ok);
    f = 10'h000;
    for (int i = 0; i < 500; i++)
    begin
      if (clk_line === 1'b1 && dat_line === 1'b0)
        break;
      #10;
    end
    ok = clk_line === 1'b1 && dat_line === 1'b0;
    if (ok)
    begin
      // answer late enough that the released clock is debounced high first
      #160;
      for (int i = 0; i < 10; i++)
      begin
        clk_low = 1'b1;
        #70;
        f[i] = dat_line;
        #10;
        clk_low = 1'b0;
        #80;
      end
      clk_low = 1'b1;
      #20;
      dat_low = 1'b1;
      #60;
      clk_low = 1'b0;
      #80;
      dat_low = 1'b0;
    end
  endtask
endmodule

// file: test/kms_shift_engine_tb_top.sv
// Purpose: self-checking bench for the shift engine
// Assumes: peripheral model on channel 2, pull-ups on every line
// Notes: channels 1 and 3 only see the engine's own drive
`include "kms_defs.svh"
module kms_shift_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, reg_wr, reg_rd, pullup_en, irq, peer_ck, peer_dt;
  logic [`KMS_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] ck_i, ck_o, ck_oe, dt_i, dt_o, dt_oe;
  logic [1:0] irq_x;
  int n_errors = 0;
  int num_checks = 0;
  assign ck_i = ~ck_oe & ~{1'b0, peer_ck, 1'b0};
  assign dt_i = ~dt_oe & ~{1'b0, peer_dt, 1'b0};
  kms_shift_engine uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_clock_line_i(ck_i),
    .port_clock_line_o(ck_o), .port_clock_line_oe(ck_oe), .port_data_line_i(dt_i),
    .port_data_line_o(dt_o), .port_data_line_oe(dt_oe), .weak_pullup_enable(pullup_en),
    .shift_interrupt_line(irq), .bitbang_irq_extra(irq_x));
  kms_peer_model peer (.clk_low(peer_ck), .dat_low(peer_dt), .clk_line(ck_i[1]),
    .dat_line(dt_i[1]));
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic cmp_reg(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp(what, exp, d);
  endtask
  task automatic wait_flag(input int bitn);
    logic [7:0] d;
    for (int i = 0; i < 400; i++)
    begin
      rd(`KMS_OFS_STATUS, d);
      if (d[bitn] === 1'b1)
        return;
    end
    n_errors++;
    $display("[FAIL] status wait expected 1 seen 0");
    print_verdict();
  endtask
  task automatic t_reset();
    cmp_reg("control", `KMS_OFS_CONTROL, `KMS_RST_CONTROL);
    cmp_reg("line out", `KMS_OFS_LINE_OUT, 8'h07);
    cmp_reg("irq enables", `KMS_OFS_IRQ_EN, 8'h00);
    wr(`KMS_OFS_STATUS, 8'hFF);
    cmp_reg("status", `KMS_OFS_STATUS, 8'h00);
    cmp_reg("unmapped", 3'h7, 8'h00);
    cmp("clock oe", 8'h07, {5'h00, ck_oe});
    cmp("pullup", 8'h00, {7'h00, pullup_en});
  endtask
  task automatic t_bitbang();
    wr(`KMS_OFS_IRQ_EN, 8'h04);
    wr(`KMS_OFS_LINE_OUT, 8'h3A);
    repeat (6) @(posedge clk);
    cmp("clock oe", 8'h00, {5'h00, ck_oe});
    cmp("data oe", 8'h05, {5'h00, dt_oe});
    cmp_reg("line levels", `KMS_OFS_LINE_IN, 8'h3A);
    cmp("bitbang irqs", 8'h07, {5'h00, irq_x, irq});
    fork
      peer.send_frame(8'hFF, 1'b1, 1'b1);
      #100 cmp("ch2 clock irq", 8'h05, {5'h00, irq_x, irq});
    join
    wr(`KMS_OFS_LINE_OUT, 8'h07);
  endtask
  task automatic t_rx(input logic [7:0] ctl, input logic [7:0] b, input logic par,
      input logic stp, input logic [7:0] st);
    wr(`KMS_OFS_LINE_OUT, 8'h07);
    cmp_reg("status cleared", `KMS_OFS_STATUS, 8'h00);
    wr(`KMS_OFS_CONTROL, ctl);
    wr(`KMS_OFS_IRQ_EN, 8'h03);
    wr(`KMS_OFS_LINE_OUT, 8'h17);
    // released clock must settle through the debounce before the start fall
    repeat (12) @(posedge clk);
    fork
      peer.send_frame(b, par, stp);
      begin
        wait_flag(0);
        cmp_reg("start status", `KMS_OFS_STATUS, 8'h11);
        cmp("start irq", 8'h01, {7'h00, irq});
      end
    join
    wait_flag(1);
    cmp_reg("end status", `KMS_OFS_STATUS, st);
    cmp_reg("rx byte", `KMS_OFS_DATA, b);
    cmp("end clocks", 8'h07, {5'h00, ck_oe});
  endtask
  task automatic t_tx();
    logic [9:0] f;
    logic ok;
    wr(`KMS_OFS_LINE_OUT, 8'h07);
    wr(`KMS_OFS_CONTROL, 8'h03);
    cmp_reg("tx line out", `KMS_OFS_LINE_OUT, 8'h07);
    cmp("tx clocks", 8'h07, {5'h00, ck_oe});
    cmp("tx data", 8'h00, {5'h00, dt_oe});
    wr(`KMS_OFS_DATA, 8'h5B);
    wr(`KMS_OFS_LINE_OUT, 8'h05);
    wr(`KMS_OFS_LINE_OUT, 8'h15);
    repeat (3) @(posedge clk);
    cmp("idle clocks", 8'h05, {5'h00, ck_oe});
    cmp("idle data", 8'h02, {5'h00, dt_oe});
    peer.recv_frame(f, ok);
    cmp("tx seen", 8'h01, {7'h00, ok});
    cmp("tx byte", 8'h5B, f[7:0]);
    cmp("tx parity stop", 8'h02, {6'h00, f[9:8]});
    wait_flag(1);
    cmp_reg("tx status", `KMS_OFS_STATUS, 8'h13);
    cmp_reg("drive bits", `KMS_OFS_LINE_OUT, 8'h17);
    cmp("tx end lines", 8'h38, {2'h0, ck_oe, dt_oe});
    wr(`KMS_OFS_LINE_OUT, 8'h07);
    cmp_reg("abort status", `KMS_OFS_STATUS, 8'h00);
    wr(`KMS_OFS_CONTROL, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bitbang();
    t_rx(8'h01, 8'hA5, 1'b1, 1'b1, 8'h13);
    t_rx(8'h21, 8'h3C, 1'b0, 1'b0, 8'h57);
    t_tx();
    print_verdict();
  end
endmodule
